// ==== rtl/fld_pkg.sv ====
package fld_pkg;

    // Clock and time base
    localparam int CLK_PERIOD_NS = 100;
    localparam int T_US_NS = 1000;
    localparam int CYC_PER_US = (T_US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_MS_US = 1000;

    // Indicator gating pattern, in microseconds
    localparam int IND_ON_US = 1;
    localparam int IND_OFF_US = 31;
    localparam int IND_PERIOD_US = IND_ON_US + IND_OFF_US;
    localparam int IND_W = $clog2(IND_PERIOD_US);

    // Setup window and quiet interval that closes a pulse burst
    localparam int SETUP_US = 128;
    localparam int TMR_W = $clog2(SETUP_US + 1);

    // Flash duration limit
    localparam int FLASH_LIMIT_MS = 800;

    // Pulse counts
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] STEP_MAX = 5'h11;
    localparam logic [CNT_W-1:0] PULSE_MIN_CNT = 5'h03;
    localparam logic [CNT_W-1:0] TORCH_STEP_OFFSET = 5'h02;
    localparam logic [CNT_W-1:0] STEP_TORCH_MIN = 5'h02;
    localparam logic [CNT_W-1:0] STEP_FLASH_MIN = 5'h06;
    localparam int TORCH_MS_MAX = int'(STEP_MAX - TORCH_STEP_OFFSET);

    // Current ratio word (sink current over bias current)
    localparam int RATIO_W = 13;
    localparam logic [RATIO_W-1:0] RATIO_OFF = 13'h0000;
    localparam logic [RATIO_W-1:0] RATIO_TORCH = 13'h0667;
    localparam logic [RATIO_W-1:0] RATIO_FULL = 13'h1de2;

    typedef enum logic [1:0] {FLD_OFF, FLD_INDICATOR, FLD_TORCH, FLD_FLASH} fld_mode_type;
    typedef enum logic [1:0] {FLD_S_IDLE, FLD_S_ARMED, FLD_S_COUNT, FLD_S_RUN} fld_state_type;

    // Mode chosen by a pulse count
    function automatic fld_mode_type fld_step_mode(input logic [CNT_W-1:0] cnt);
        if (cnt < STEP_TORCH_MIN) begin
            return FLD_INDICATOR;
        end else if (cnt < STEP_FLASH_MIN) begin
            return FLD_TORCH;
        end
        return FLD_FLASH;
    endfunction : fld_step_mode

    // Ratio chosen by a pulse count; indicator steps carry the torch ratio, gated later
    function automatic logic [RATIO_W-1:0] fld_step_ratio(input logic [CNT_W-1:0] cnt);
        case (cnt)
            5'h00, 5'h01: return RATIO_TORCH;
            5'h02: return 13'h01c0;
            5'h03: return 13'h03a1;
            5'h04: return 13'h0582;
            5'h05: return 13'h0763;
            5'h06: return 13'h0943;
            5'h07: return 13'h0b24;
            5'h08: return 13'h0d05;
            5'h09: return 13'h0ee6;
            5'h0a: return 13'h10c7;
            5'h0b: return 13'h12a8;
            5'h0c: return 13'h1489;
            5'h0d: return 13'h1669;
            5'h0e: return 13'h184a;
            5'h0f: return 13'h1a2b;
            5'h10: return 13'h1c0c;
            default: return RATIO_FULL;
        endcase
    endfunction : fld_step_ratio

endpackage : fld_pkg

// ==== rtl/fld_if.sv ====
`timescale 1ns/1ps
// Synchronised pin levels, their edges and the time base ticks
interface fld_if;
    logic p1;
    logic p2;
    logic p1_rise;
    logic p1_fall;
    logic p2_rise;
    logic p2_fall;
    logic us_tick;
    logic ms_tick;
    modport sync (output p1, output p2, output p1_rise, output p1_fall, output p2_rise, output p2_fall);
    modport tick (output us_tick, output ms_tick);
    modport core (input p1, input p2, input p1_rise, input p1_fall, input p2_rise, input p2_fall,
                  input us_tick, input ms_tick);
endinterface : fld_if

// ==== rtl/fld_sync.sv ====
`timescale 1ns/1ps
module fld_sync (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_pin1,
    input wire logic i_pin2,
    fld_if.sync o_bus
);
    import fld_pkg::*;

    logic [1:0] meta_r; // First stage, read only by the second
    logic [1:0] sync_r; // Clean levels
    logic [1:0] prev_r; // Levels one cycle ago, for edges

    // Two-stage synchroniser plus history for the edge detector
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_r <= 2'h0;
            sync_r <= 2'h0;
            prev_r <= 2'h0;
        end else begin
            meta_r <= {i_pin2, i_pin1};
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    // Levels and single-cycle edge pulses, all aligned to sync_r
    assign o_bus.p1 = sync_r[0];
    assign o_bus.p2 = sync_r[1];
    assign o_bus.p1_rise = sync_r[0] & ~prev_r[0];
    assign o_bus.p1_fall = ~sync_r[0] & prev_r[0];
    assign o_bus.p2_rise = sync_r[1] & ~prev_r[1];
    assign o_bus.p2_fall = ~sync_r[1] & prev_r[1];
endmodule : fld_sync

// ==== rtl/fld_tick.sv ====
`timescale 1ns/1ps
module fld_tick #(
    parameter int CYC_PER_US_P = fld_pkg::CYC_PER_US,
    parameter int US_PER_MS_P = fld_pkg::T_MS_US
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    fld_if.tick o_bus
);
    import fld_pkg::*;

    localparam int CW = $clog2(CYC_PER_US_P + 1);
    localparam int MW = $clog2(US_PER_MS_P + 1);

    logic [CW-1:0] cyc_r; // Cycles within the current microsecond
    logic [MW-1:0] us_r;  // Microseconds within the current millisecond

    // Microsecond divider
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cyc_r <= '0;
            o_bus.us_tick <= 1'b0;
        end else if (cyc_r == CW'(CYC_PER_US_P - 1)) begin
            cyc_r <= '0;
            o_bus.us_tick <= 1'b1;
        end else begin
            cyc_r <= cyc_r + 1'b1;
            o_bus.us_tick <= 1'b0;
        end
    end

    // Millisecond divider, advanced by microsecond ticks only
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            us_r <= '0;
            o_bus.ms_tick <= 1'b0;
        end else if (o_bus.us_tick && us_r == MW'(US_PER_MS_P - 1)) begin
            us_r <= '0;
            o_bus.ms_tick <= 1'b1;
        end else begin
            if (o_bus.us_tick) begin
                us_r <= us_r + 1'b1;
            end
            o_bus.ms_tick <= 1'b0;
        end
    end
endmodule : fld_tick

// ==== rtl/fld_top.sv ====
`timescale 1ns/1ps
module fld_top #(
    parameter bit PULSE_COUNT_VARIANT = 1'b0,
    parameter int US_PER_MS = fld_pkg::T_MS_US,
    parameter int FLASH_LIMIT_MS = fld_pkg::FLASH_LIMIT_MS
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_first_control_pin,
    input wire logic i_second_control_pin,
    output fld_pkg::fld_mode_type o_mode,
    output logic [fld_pkg::RATIO_W-1:0] o_current_ratio,
    output logic o_sink_on,
    output logic o_flash_timed_out
);
    import fld_pkg::*;

    // Widths that follow the parameters
    localparam int PW = $clog2(TORCH_MS_MAX * US_PER_MS + 1);
    localparam int FW = $clog2(FLASH_LIMIT_MS + 1);

    logic rst_meta_r; // Reset release, first stage
    logic rst_n_r;    // Reset used by all other logic

    fld_state_type state_r;    // Pulse-count session state
    logic method_b_r;          // Start method latched at the first second-pin rise
    logic [CNT_W-1:0] cnt_r;   // Pulse counter, saturating
    logic [TMR_W-1:0] tmr_us_r; // Window / quiet timer in microseconds
    logic [PW-1:0] pulse_us_r; // Remaining pulsed-indicator time
    logic [IND_W-1:0] ind_us_r; // Phase inside the indicator period
    logic [FW-1:0] flash_ms_r; // Time spent in flash mode
    logic timed_out_r;         // Flash limit reached

    logic both_low;   // Both pins low
    logic any_edge;   // Any pin edge this cycle
    logic tmr_clr;    // Restart the microsecond timer
    logic tmr_hit;    // Timer reaches the window length this cycle
    logic tmr_done;   // Timer at the window length
    logic cnt_inc;    // Count one pulse
    logic cnt_clr;    // Drop the count
    logic pulse_start; // Load the pulsed-indicator timer
    logic ind_on;     // Indicator on-phase
    fld_mode_type tgt_mode; // Decoded mode before the output flop
    logic [RATIO_W-1:0] tgt_ratio; // Decoded ratio before the output flop

    fld_if bus ();

    // Reset: assert at once, release after two clean edges
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    // Pin synchroniser and edge detector
    fld_sync u_sync (
        .i_clk(i_clk),
        .i_rst_n(rst_n_r),
        .i_pin1(i_first_control_pin),
        .i_pin2(i_second_control_pin),
        .o_bus(bus)
    );

    // Microsecond and millisecond enables
    fld_tick #(
        .CYC_PER_US_P(CYC_PER_US),
        .US_PER_MS_P(US_PER_MS)
    ) u_tick (
        .i_clk(i_clk),
        .i_rst_n(rst_n_r),
        .o_bus(bus)
    );

    assign both_low = !bus.p1 && !bus.p2;
    assign any_edge = bus.p1_rise || bus.p1_fall || bus.p2_rise || bus.p2_fall;

    // Timer restart: static variant and method B measure quiet time since the last edge;
    // method A measures a fixed delay from the session start instead
    always_comb begin
        if (PULSE_COUNT_VARIANT) begin
            tmr_clr = (state_r == FLD_S_IDLE && !both_low) ||
                      (state_r == FLD_S_COUNT && method_b_r && any_edge);
        end else begin
            tmr_clr = any_edge;
        end
    end

    assign tmr_done = (tmr_us_r == TMR_W'(SETUP_US));
    assign tmr_hit = bus.us_tick && !tmr_clr && (tmr_us_r == TMR_W'(SETUP_US - 1));

    // Microsecond timer, saturates at the window length
    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            tmr_us_r <= '0;
        end else if (tmr_clr) begin
            tmr_us_r <= '0;
        end else if (bus.us_tick && !tmr_done) begin
            tmr_us_r <= tmr_us_r + 1'b1;
        end
    end

    // Pulse counting: second-pin falls with the first pin low, or first-pin falls in a session
    always_comb begin
        if (PULSE_COUNT_VARIANT) begin
            cnt_inc = (state_r == FLD_S_COUNT) && bus.p1_fall;
            cnt_clr = (state_r == FLD_S_IDLE);
        end else begin
            cnt_inc = !bus.p1 && bus.p2_fall;
            cnt_clr = tmr_hit || bus.p1;
        end
    end

    // Saturating pulse counter; 17 and above behave alike
    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            cnt_r <= '0;
        end else if (cnt_clr) begin
            cnt_r <= '0;
        end else if (cnt_inc && cnt_r != STEP_MAX) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    // A burst closes after a quiet window; fewer than three pulses are noise
    assign pulse_start = !PULSE_COUNT_VARIANT && tmr_hit && both_low && cnt_r >= PULSE_MIN_CNT;

    // Self-timed indicator pulse; the host does nothing further once loaded
    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            pulse_us_r <= '0;
        end else if (pulse_start) begin
            pulse_us_r <= PW'(int'(cnt_r - TORCH_STEP_OFFSET) * US_PER_MS);
        end else if (bus.us_tick && pulse_us_r != '0) begin
            pulse_us_r <= pulse_us_r - 1'b1;
        end
    end

    // Session sequencer for the pulse-count variant
    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r <= FLD_S_IDLE;
            method_b_r <= 1'b0;
        end else if (PULSE_COUNT_VARIANT) begin
            case (state_r)
                FLD_S_IDLE: begin
                    // A second-pin rise straight from idle picks the method at once
                    if (bus.p2_rise) begin
                        method_b_r <= !bus.p1;
                        state_r <= FLD_S_COUNT;
                    end else if (!both_low) begin
                        state_r <= FLD_S_ARMED;
                    end
                end
                FLD_S_ARMED: begin
                    if (bus.p2_rise) begin
                        method_b_r <= !bus.p1;
                        state_r <= FLD_S_COUNT;
                    end else if (both_low) begin
                        state_r <= FLD_S_IDLE;
                    end
                end
                FLD_S_COUNT: begin
                    if (method_b_r) begin
                        // Method B: current starts at the second rise of the second pin
                        if (bus.p2_rise) begin
                            state_r <= FLD_S_RUN;
                        end else if (both_low && tmr_done) begin
                            state_r <= FLD_S_IDLE;
                        end
                    end else begin
                        // Method A: current starts a fixed delay after the session start
                        if (both_low) begin
                            state_r <= FLD_S_IDLE;
                        end else if (tmr_done) begin
                            state_r <= FLD_S_RUN;
                        end
                    end
                end
                FLD_S_RUN: begin
                    if (both_low) begin
                        state_r <= FLD_S_IDLE;
                    end
                end
                default: begin
                    state_r <= FLD_S_IDLE;
                end
            endcase
        end
    end

    // Mode and ratio decode
    always_comb begin
        tgt_mode = FLD_OFF;
        tgt_ratio = RATIO_OFF;
        if (PULSE_COUNT_VARIANT) begin
            if (state_r == FLD_S_RUN && !both_low) begin
                tgt_mode = fld_step_mode(cnt_r);
                tgt_ratio = fld_step_ratio(cnt_r);
            end
        end else begin
            case ({bus.p1, bus.p2})
                2'b10: begin
                    tgt_mode = FLD_INDICATOR;
                    tgt_ratio = RATIO_TORCH;
                end
                2'b01: begin
                    tgt_mode = FLD_TORCH;
                    tgt_ratio = RATIO_TORCH;
                end
                2'b11: begin
                    tgt_mode = FLD_FLASH;
                    tgt_ratio = RATIO_FULL;
                end
                default: begin
                    // Pins low: only a running pulsed indicator keeps the sink busy
                    if (pulse_us_r != '0) begin
                        tgt_mode = FLD_TORCH;
                        tgt_ratio = RATIO_TORCH;
                    end
                end
            endcase
        end
    end

    // Indicator phase; first on-time may be short because the tick phase is free-running
    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ind_us_r <= '0;
        end else if (tgt_mode != FLD_INDICATOR) begin
            ind_us_r <= '0;
        end else if (bus.us_tick) begin
            ind_us_r <= (ind_us_r == IND_W'(IND_PERIOD_US - 1)) ? '0 : ind_us_r + 1'b1;
        end
    end

    assign ind_on = (ind_us_r < IND_W'(IND_ON_US));

    // Flash limit timer, cleared whenever the mode is not flash
    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            flash_ms_r <= '0;
            timed_out_r <= 1'b0;
        end else if (tgt_mode != FLD_FLASH) begin
            flash_ms_r <= '0;
            timed_out_r <= 1'b0;
        end else if (bus.ms_tick && !timed_out_r) begin
            if (flash_ms_r == FW'(FLASH_LIMIT_MS - 1)) begin
                timed_out_r <= 1'b1;
            end else begin
                flash_ms_r <= flash_ms_r + 1'b1;
            end
        end
    end

    // Output flops
    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            o_mode <= FLD_OFF;
            o_current_ratio <= RATIO_OFF;
            o_sink_on <= 1'b0;
            o_flash_timed_out <= 1'b0;
        end else begin
            o_mode <= tgt_mode;
            o_current_ratio <= tgt_ratio;
            o_sink_on <= (tgt_mode != FLD_OFF) && !timed_out_r &&
                         (tgt_mode != FLD_INDICATOR || ind_on);
            o_flash_timed_out <= timed_out_r;
        end
    end

    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!rst_n_r);

    sequence s_static_flash;
        !PULSE_COUNT_VARIANT && bus.p1 && bus.p2;
    endsequence

    sequence s_ind_off_run;
        (!o_sink_on || o_mode != FLD_INDICATOR) [*8];
    endsequence

    AST_STATIC_IND: assert property (!PULSE_COUNT_VARIANT && bus.p1 && !bus.p2 |=> o_mode == FLD_INDICATOR)
        else $error("static indicator decode wrong");
    AST_STATIC_FLASH: assert property (s_static_flash
                                       |=> o_mode == FLD_FLASH && o_current_ratio == RATIO_FULL)
        else $error("static flash decode wrong");
    AST_IND_GAP: assert property (o_mode == FLD_INDICATOR && $fell(o_sink_on) |-> s_ind_off_run)
        else $error("indicator off phase too short");
    AST_TIMER_ONLY_FLASH: assert property (tgt_mode != FLD_FLASH |=> flash_ms_r == '0 && !timed_out_r)
        else $error("flash timer ran outside flash");
    AST_TIMEOUT_OFF: assert property (timed_out_r && tgt_mode == FLD_FLASH |=> !o_sink_on)
        else $error("sink on after flash limit");
    AST_PULSE_RUN: assert property (!PULSE_COUNT_VARIANT && pulse_us_r > 1 && both_low
                                    |=> o_mode == FLD_TORCH)
        else $error("pulsed indicator not driving torch");
    AST_PULSE_IGNORE: assert property (tmr_hit && both_low && cnt_r < PULSE_MIN_CNT && pulse_us_r == '0
                                       |=> pulse_us_r == '0)
        else $error("short burst started a pulse");
    AST_PULSE_LEN: assert property (pulse_start && cnt_r == PULSE_MIN_CNT |=> pulse_us_r == US_PER_MS)
        else $error("three pulses not one millisecond");
    AST_METHOD: assert property (PULSE_COUNT_VARIANT && state_r == FLD_S_ARMED && bus.p2_rise
                                 |=> state_r == FLD_S_COUNT && method_b_r == !$past(bus.p1))
        else $error("start method latched wrong");
    AST_METHOD_B: assert property (PULSE_COUNT_VARIANT && state_r == FLD_S_COUNT && method_b_r
                                   && bus.p2_rise |=> state_r == FLD_S_RUN)
        else $error("method B did not start on second rise");
    AST_RUN_RATIO: assert property (PULSE_COUNT_VARIANT && state_r == FLD_S_RUN && !both_low
                                    |=> o_current_ratio == fld_step_ratio($past(cnt_r)))
        else $error("ratio does not follow count");
endmodule : fld_top

// ==== test/fld_host.sv ====
`timescale 1ns/1ps
// Host GPIO model; levels change on the falling edge and stand whole microseconds
module fld_host (
    input wire logic i_clk,
    output logic o_first_control_pin,
    output logic o_second_control_pin
);
    // Pull-downs keep both pins low until the host acts
    initial begin
        o_first_control_pin = 1'b0;
        o_second_control_pin = 1'b0;
    end
    // Drive both pins, then hold them for whole microseconds of clock cycles
    task automatic set(input logic a, input logic b, input int us);
        @(negedge i_clk);
        o_first_control_pin = a;
        o_second_control_pin = b;
        repeat (us * fld_pkg::CYC_PER_US - 1) @(negedge i_clk);
    endtask : set
endmodule : fld_host

// ==== test/tb_fld_top.sv ====
`timescale 1ns/1ps
module tb_fld_top;
    import fld_pkg::*;
    localparam int US_MS = 10; // Shortened millisecond
    localparam int LIMIT = 5; // Shortened flash limit
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic p1_a, p2_a, p1_b, p2_b; // Pins of the two variants
    fld_mode_type mode_a, mode_b;
    logic [RATIO_W-1:0] ratio_a, ratio_b;
    logic sink_a, sink_b, tout_a, tout_b;
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;
    // Static table indexed by {first, second}
    fld_mode_type exp_mode [4] = '{FLD_OFF, FLD_TORCH, FLD_INDICATOR, FLD_FLASH};
    logic [RATIO_W-1:0] exp_ratio [4] = '{RATIO_OFF, RATIO_TORCH, RATIO_TORCH, RATIO_FULL};

    fld_host fld_host_inst (.i_clk(clk), .o_first_control_pin(p1_a), .o_second_control_pin(p2_a));
    fld_host fld_host_b_inst (.i_clk(clk), .o_first_control_pin(p1_b), .o_second_control_pin(p2_b));
    fld_top #(.PULSE_COUNT_VARIANT(1'b0), .US_PER_MS(US_MS), .FLASH_LIMIT_MS(LIMIT)) fld_top_inst (
        .i_clk(clk), .i_arst_n(arst_n), .i_first_control_pin(p1_a), .i_second_control_pin(p2_a),
        .o_mode(mode_a), .o_current_ratio(ratio_a), .o_sink_on(sink_a), .o_flash_timed_out(tout_a));
    fld_top #(.PULSE_COUNT_VARIANT(1'b1), .US_PER_MS(US_MS), .FLASH_LIMIT_MS(LIMIT)) fld_top_b_inst (
        .i_clk(clk), .i_arst_n(arst_n), .i_first_control_pin(p1_b), .i_second_control_pin(p2_b),
        .o_mode(mode_b), .o_current_ratio(ratio_b), .o_sink_on(sink_b), .o_flash_timed_out(tout_b));

    // 10 MHz clock
    always #50 clk = ~clk;

    // Hang guard, well above the expected run of about 29000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            mismatches++;
            results();
        end
    end

    // Compare one value, count it, report a mismatch
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Verdict and end of run
    task automatic results();
        $display("Checks %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results

    // All four static pin pairs
    task automatic test_static();
        logic [1:0] p;
        for (int i = 0; i < 4; i++) begin
            p = i[1:0];
            fld_host_inst.set(p[1], p[0], 2);
            check(mode_a, exp_mode[i]);
            check(ratio_a, exp_ratio[i]);
        end
        $display("Static decode done");
    endtask : test_static

    // Any 32 us window of indicator holds exactly 1 us of sink current
    task automatic test_indicator();
        int on = 0;
        fld_host_inst.set(1'b1, 1'b0, 40);
        repeat (320) begin
            @(negedge clk);
            on += int'(sink_a);
        end
        check(on, 10);
        $display("Indicator duty done");
    endtask : test_indicator

    // Flash ends on its own within the limit band; torch never does
    task automatic test_flash();
        int t = 300;
        fld_host_inst.set(1'b1, 1'b1, 30);
        check({sink_a, tout_a}, 2'b10);
        while (tout_a !== 1'b1 && t < 1000) begin
            @(negedge clk);
            t++;
        end
        check(t >= (LIMIT - 1) * US_MS * 10 && t <= (LIMIT + 1) * US_MS * 10 + 20, 1);
        check({mode_a, sink_a}, {FLD_FLASH, 1'b0});
        fld_host_inst.set(1'b0, 1'b1, 100);
        check({sink_a, tout_a}, 2'b10);
        fld_host_inst.set(1'b0, 1'b0, 150);
        $display("Flash limit done");
    endtask : test_flash

    // Pulsed indicator: n falls on the second pin, then the device times itself
    task automatic test_pulsed(input int n);
        int on = 0;
        int exp;
        exp = n < 3 ? 0 : (n > 16 ? 15 : n - 2) * US_MS * 10;
        for (int i = 0; i < n; i++) begin
            fld_host_inst.set(1'b0, 1'b1, 1);
            fld_host_inst.set(1'b0, 1'b0, 1);
        end
        repeat (3000) begin
            @(negedge clk);
            on += int'(sink_a);
        end
        check(on + 12 >= exp && on <= exp + 12, 1);
        check(mode_a, FLD_OFF);
        $display("Pulsed indicator with %0d falls done", n);
    endtask : test_pulsed

    // Method B: strobe rise with first pin low, count, second rise starts current
    task automatic test_method_b(input int n, input fld_mode_type m, input logic [RATIO_W-1:0] r);
        fld_host_b_inst.set(1'b0, 1'b0, 150);
        fld_host_b_inst.set(1'b0, 1'b1, 1);
        for (int i = 0; i < n; i++) begin
            fld_host_b_inst.set(1'b1, 1'b1, 1);
            fld_host_b_inst.set(1'b0, 1'b1, 1);
        end
        fld_host_b_inst.set(1'b0, 1'b0, 1);
        check(mode_b, FLD_OFF);
        fld_host_b_inst.set(1'b0, 1'b1, 2);
        check({mode_b, ratio_b}, {m, r});
        if (m != FLD_INDICATOR) begin
            check(sink_b, 1'b1);
        end
        // Hold the strobe past the flash limit; only flash steps may time out
        fld_host_b_inst.set(1'b0, 1'b1, 60);
        check(tout_b, m == FLD_FLASH);
        fld_host_b_inst.set(1'b0, 1'b0, 2);
        check(mode_b, FLD_OFF);
        $display("Method B with %0d pulses done", n);
    endtask : test_method_b

    // Method A: first pin high at strobe rise, current after the fixed delay
    task automatic test_method_a(input int n, input fld_mode_type m, input logic [RATIO_W-1:0] r);
        fld_host_b_inst.set(1'b0, 1'b0, 150);
        fld_host_b_inst.set(1'b1, 1'b0, 1);
        fld_host_b_inst.set(1'b1, 1'b1, 1);
        for (int i = 0; i < n; i++) begin
            fld_host_b_inst.set(1'b0, 1'b1, 1);
            fld_host_b_inst.set(1'b1, 1'b1, 1);
        end
        check(mode_b, FLD_OFF);
        repeat (1500) @(negedge clk);
        check({mode_b, ratio_b}, {m, r});
        fld_host_b_inst.set(1'b0, 1'b0, 2);
        check(mode_b, FLD_OFF);
        $display("Method A with %0d pulses done", n);
    endtask : test_method_a

    // Main sequence; reset stands 20 cycles and is released off the sampling edge
    initial begin
        repeat (20) @(negedge clk);
        arst_n = 1'b1;
        repeat (10) @(negedge clk);
        test_static();
        test_indicator();
        test_flash();
        test_pulsed(2);
        test_pulsed(3);
        test_pulsed(20);
        test_method_b(0, FLD_INDICATOR, RATIO_TORCH);
        test_method_b(3, FLD_TORCH, 13'h03a1);
        test_method_b(17, FLD_FLASH, 13'h1de2);
        test_method_b(20, FLD_FLASH, 13'h1de2);
        test_method_a(2, FLD_TORCH, 13'h01c0);
        test_method_a(6, FLD_FLASH, 13'h0943);
        results();
    end
endmodule : tb_fld_top
